//--- common/epphs_pkg.sv
// Constants and types for the ECP host-side parallel port.
// Assumes a single 10 MHz clock and an 8-bit ISA-style register bus.
package epphs_pkg;

	localparam int WORD_W = 8;
	localparam int ADDR_W = 11;
	localparam int DEPTH  = 16;
	localparam int PTR_W  = 4;
	localparam int CNT_W  = 5;

	localparam logic [10:0] OFF_PORT_DATA   = 11'h000;
	localparam logic [10:0] OFF_LINE_STATUS = 11'h001;
	localparam logic [10:0] OFF_LINE_CTRL   = 11'h002;
	localparam logic [10:0] OFF_FIFO_PORT   = 11'h400;
	localparam logic [10:0] OFF_CAP_B       = 11'h401;
	localparam logic [10:0] OFF_EXT_CTRL    = 11'h402;

	localparam logic [2:0] MODE_SPP    = 3'h0;
	localparam logic [2:0] MODE_PS2    = 3'h1;
	localparam logic [2:0] MODE_COMPAT_FIFO_PORT  = 3'h2;
	localparam logic [2:0] MODE_ECP    = 3'h3;
	localparam logic [2:0] MODE_TEST   = 3'h6;
	localparam logic [2:0] MODE_CONFIG = 3'h7;

	localparam int LC_STROBE = 0;
	localparam int LC_AUTOFD = 1;
	localparam int LC_INIT   = 2;
	localparam int LC_SELIN  = 3;
	localparam int LC_ACKIE  = 4;
	localparam int LC_DIR    = 5;

	localparam int RLE_CMD_BIT = 7;

	localparam logic [7:0] CAP_A_VALUE   = 8'h10;
	localparam logic [5:0] LINE_CTRL_RST = 6'h00;
	localparam logic [2:0] MODE_RST      = 3'h0;
	localparam logic [4:0] SVC_LEVEL     = 5'h08;

	typedef enum logic [2:0] {
		XF_IDLE,
		XF_SETUP,
		XF_STROBE,
		XF_RELEASE,
		RV_REQ,
		RV_DONE
	} epphs_xfer_type;

	typedef struct packed {
		logic       isCmd;
		logic [7:0] value;
	} epphs_entry_type;

	typedef struct packed {
		logic       ackN;
		logic       periphBusy;
		logic       paperErrorLine;
		logic       select;
		logic       faultN;
		logic [7:0] dataIn;
	} epphs_pins_in_type;

	typedef struct packed {
		logic       strobeN;
		logic       autoFdN;
		logic       reverseReqN;
		logic       selectInN;
		logic [7:0] dataOut;
		logic       dataOe;
	} epphs_pins_out_type;

	typedef struct packed {
		epphs_entry_type [DEPTH-1:0] mem;
		logic [PTR_W-1:0]            wp;
		logic [PTR_W-1:0]            rp;
		logic [CNT_W-1:0]            cnt;
		epphs_entry_type             last;
	} epphs_fifo_state_type;

	typedef struct packed {
		epphs_xfer_type     st;
		logic [7:0]         dataLatch;
		logic [5:0]         lineCtrl;
		logic [2:0]         mode;
		logic               errIrqEn;
		logic               dmaReqEn;
		logic               svcFlag;
		logic [7:0]         rdData;
		epphs_pins_out_type pins;
		logic               irq;
		logic               dmaReq;
		logic               rlePend;
		logic [7:0]         rleCnt;
		logic [7:0]         repByte;
		logic [7:0]         repLeft;
		logic               ackPrev;
		logic               faultPrev;
	} epphs_port_state_type;

	localparam epphs_pins_out_type PINS_RST = '{
		strobeN: 1'b1, autoFdN: 1'b1, reverseReqN: 1'b0,
		selectInN: 1'b1, dataOut: 8'h00, dataOe: 1'b1};

	localparam epphs_port_state_type PORT_RST = '{
		st: XF_IDLE, dataLatch: 8'h00, lineCtrl: LINE_CTRL_RST,
		mode: MODE_RST, errIrqEn: 1'b0, dmaReqEn: 1'b0,
		svcFlag: 1'b0, rdData: 8'h00, pins: PINS_RST, irq: 1'b0,
		dmaReq: 1'b0, rlePend: 1'b0, rleCnt: 8'h00, repByte: 8'h00,
		repLeft: 8'h00, ackPrev: 1'b1, faultPrev: 1'b1};

endpackage

//--- rtl/epphs_fifo.sv
// Shared 16-entry byte FIFO with a command tag bit per entry.
// Assumes callers never push and pop from conflicting sources.
`timescale 1ns/1ps
module epphs_fifo (
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	input  wire logic                      flush,
	input  wire logic                      push,
	input  wire epphs_pkg::epphs_entry_type pushData,
	input  wire logic                      pop,
	output epphs_pkg::epphs_entry_type      popData,
	output logic                           full,
	output logic                           empty,
	output logic [epphs_pkg::CNT_W-1:0]    level
);

	epphs_pkg::epphs_fifo_state_type r;
	epphs_pkg::epphs_fifo_state_type n;
	logic doPush;
	logic doPop;

	assign full  = (r.cnt == 5'h10);
	assign empty = (r.cnt == 5'h00);
	assign level = r.cnt;
	// Empty read repeats the last byte instead of stalling
	assign popData = empty ? r.last : r.mem[r.rp];

	always_comb begin
		n = r;
		// Full drops the write, empty ignores the pop
		doPush = push && !full;
		doPop  = pop && !empty;
		if (flush) begin
			n.wp  = '0;
			n.rp  = '0;
			n.cnt = '0;
		end else begin
			if (doPush) begin
				n.mem[r.wp] = pushData;
				n.wp = r.wp + 4'h1;
			end
			if (doPop) begin
				n.last = r.mem[r.rp];
				n.rp = r.rp + 4'h1;
			end
			if (doPush && !doPop) begin
				n.cnt = r.cnt + 5'h01;
			end else if (doPop && !doPush) begin
				n.cnt = r.cnt - 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

endmodule // epphs_fifo

//--- rtl/epphs_port.sv
// ECP-capable parallel port: register file, shared FIFO, link handshakes.
// Assumes bus strobes and pin inputs are synchronous to clk_sys.
//
// Behaviour
// - Every word on the bus and the data lines is eight bits.
// - All FIFO register views share one sixteen-byte FIFO.
// - Legacy printer port registers and pins behave as before.
// - No negotiation; automatic burst channel with DMA both directions.
// - Compatibility FIFO mode strobes bytes out by hardware handshake.
// - Reverse RLE count byte makes the next data byte repeat.
// - Compression is optional; this port does not compress.
// - Forward bytes latch on strobe assertion, interlocked with busy.
// - Port asserts host-ack low to request each reverse byte.
// - Reverse request pin low for reverse, high for forward.
// - In ECP mode, data lines driven only while forward is acknowledged.
// - Select-in line held deasserted throughout ECP mode.
// - Fault raises error interrupt in forward only; never turns link.
// - Status and control registers reachable in every mode.
// - Mode codes: 011 ECP, 010 FIFO, 110 test, 111 config.
`timescale 1ns/1ps
module epphs_port (
	input  wire logic                         clk_sys,
	input  wire logic                         resetn,
	input  wire logic [epphs_pkg::ADDR_W-1:0] busAddr,
	input  wire logic                         busWrStb,
	input  wire logic                         busRdStb,
	input  wire logic [epphs_pkg::WORD_W-1:0] busWrData,
	output logic [epphs_pkg::WORD_W-1:0]      busRdData,
	input  wire logic                         dmaAck,
	output logic                              dmaReq,
	output logic                              irq,
	input  wire epphs_pkg::epphs_pins_in_type pinsIn,
	output epphs_pkg::epphs_pins_out_type     pinsOut
);

	epphs_pkg::epphs_port_state_type r;
	epphs_pkg::epphs_port_state_type n;

	logic                       fifoFlush;
	logic                       fifoPush;
	epphs_pkg::epphs_entry_type fifoPushData;
	logic                       fifoPop;
	epphs_pkg::epphs_entry_type fifoPopData;
	logic                       fifoFull;
	logic                       fifoEmpty;
	logic [epphs_pkg::CNT_W-1:0] fifoLevel;

	logic dirIn;
	logic fwdEcp;
	logic revEcp;
	logic txMode;
	logic fifoMode;
	logic fifoAcc;
	logic faultFell;
	logic ackRose;

	// One FIFO serves every FIFO view
	epphs_fifo u_fifo (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.flush    (fifoFlush),
		.push     (fifoPush),
		.pushData (fifoPushData),
		.pop      (fifoPop),
		.popData  (fifoPopData),
		.full     (fifoFull),
		.empty    (fifoEmpty),
		.level    (fifoLevel)
	);

	assign busRdData = r.rdData;
	assign dmaReq    = r.dmaReq;
	assign irq       = r.irq;
	assign pinsOut   = r.pins;

	always_comb begin
		n = r;
		fifoFlush    = 1'b0;
		fifoPush     = 1'b0;
		fifoPushData = '0;
		fifoPop      = 1'b0;

		dirIn  = r.lineCtrl[epphs_pkg::LC_DIR];
		// Mode decode
		fwdEcp = (r.mode == epphs_pkg::MODE_ECP) && !dirIn;
		revEcp = (r.mode == epphs_pkg::MODE_ECP) && dirIn;
		txMode = (r.mode == epphs_pkg::MODE_COMPAT_FIFO_PORT) || fwdEcp;
		fifoMode = (r.mode == epphs_pkg::MODE_COMPAT_FIFO_PORT)
			|| (r.mode == epphs_pkg::MODE_ECP)
			|| (r.mode == epphs_pkg::MODE_TEST);
		// In the FIFO modes a DMA acknowledge always targets the FIFO view
		fifoAcc = fifoMode
			&& (dmaAck || busAddr == epphs_pkg::OFF_FIFO_PORT);
		faultFell = r.faultPrev && !pinsIn.faultN;
		ackRose   = !r.ackPrev && pinsIn.ackN;
		n.faultPrev = pinsIn.faultN;
		n.ackPrev   = pinsIn.ackN;

		// Register writes
		if (busWrStb) begin
			if (fifoAcc) begin
				// FIFO writes only while data flows outward, or in test mode
				if (txMode || r.mode == epphs_pkg::MODE_TEST) begin
					fifoPush = 1'b1;
					fifoPushData = '{isCmd: 1'b0, value: busWrData};
				end
			end else begin
				case (busAddr)
				epphs_pkg::OFF_PORT_DATA: begin
					if (r.mode == epphs_pkg::MODE_ECP) begin
						// Address or RLE byte, forward only
						if (!dirIn) begin
							fifoPush = 1'b1;
							fifoPushData = '{isCmd: 1'b1,
								value: busWrData};
						end
					end else begin
						n.dataLatch = busWrData;
					end
				end
				epphs_pkg::OFF_LINE_CTRL: begin
					n.lineCtrl = busWrData[5:0];
				end
				epphs_pkg::OFF_EXT_CTRL: begin
					n.mode     = busWrData[7:5];
					n.errIrqEn = busWrData[4];
					n.dmaReqEn = busWrData[3];
					n.svcFlag  = busWrData[2];
					// Entering SPP or PS2 mode discards stale bytes
					if (busWrData[7:5] == epphs_pkg::MODE_SPP
						|| busWrData[7:5] == epphs_pkg::MODE_PS2) begin
						fifoFlush = 1'b1;
					end
				end
				default: begin
				end
				endcase
			end
		end

		// Register reads
		if (busRdStb) begin
			if (fifoAcc) begin
				n.rdData = fifoPopData.value;
				if (revEcp || r.mode == epphs_pkg::MODE_TEST) begin
					fifoPop = 1'b1;
				end
			end else begin
				case (busAddr)
				epphs_pkg::OFF_PORT_DATA: begin
					if (r.mode == epphs_pkg::MODE_SPP
						|| r.mode == epphs_pkg::MODE_PS2) begin
						n.rdData = pinsIn.dataIn;
					end else begin
						n.rdData = 8'h00;
					end
				end
				epphs_pkg::OFF_LINE_STATUS: begin
					// Status readable in any mode
					n.rdData = {!pinsIn.periphBusy, pinsIn.ackN,
						pinsIn.paperErrorLine, pinsIn.select,
						pinsIn.faultN, 3'h0};
				end
				epphs_pkg::OFF_LINE_CTRL: begin
					n.rdData = {2'h0, r.lineCtrl};
				end
				epphs_pkg::OFF_FIFO_PORT: begin
					if (r.mode == epphs_pkg::MODE_CONFIG) begin
						n.rdData = epphs_pkg::CAP_A_VALUE;
					end else begin
						n.rdData = 8'h00;
					end
				end
				epphs_pkg::OFF_CAP_B: begin
					// Compress bit reads zero: no compressor
					if (r.mode == epphs_pkg::MODE_CONFIG) begin
						n.rdData = {1'b0, r.irq, 6'h00};
					end else begin
						n.rdData = 8'h00;
					end
				end
				epphs_pkg::OFF_EXT_CTRL: begin
					n.rdData = {r.mode, r.errIrqEn, r.dmaReqEn,
						r.svcFlag, fifoFull, fifoEmpty};
				end
				default: begin
					n.rdData = 8'h00;
				end
				endcase
			end
		end

		// Static pin levels per mode
		if (r.mode == epphs_pkg::MODE_ECP) begin
			n.pins.selectInN   = 1'b1;
			n.pins.reverseReqN = !dirIn;
			// Release the bus as soon as reverse is selected or forward is not acknowledged
			n.pins.dataOe = !dirIn && pinsIn.paperErrorLine;
		end else begin
			n.pins.selectInN   = !n.lineCtrl[epphs_pkg::LC_SELIN];
			n.pins.reverseReqN = n.lineCtrl[epphs_pkg::LC_INIT];
			if (r.mode == epphs_pkg::MODE_PS2) begin
				n.pins.dataOe = !n.lineCtrl[epphs_pkg::LC_DIR];
			end else begin
				n.pins.dataOe = 1'b1;
			end
		end

		// Link handshake engine
		if (!(r.mode == epphs_pkg::MODE_COMPAT_FIFO_PORT
			|| r.mode == epphs_pkg::MODE_ECP)) begin
			n.st = epphs_pkg::XF_IDLE;
			n.pins.strobeN = !n.lineCtrl[epphs_pkg::LC_STROBE];
			n.pins.autoFdN = !n.lineCtrl[epphs_pkg::LC_AUTOFD];
			n.rlePend = 1'b0;
			n.repLeft = 8'h00;
			if (r.mode == epphs_pkg::MODE_SPP
				|| r.mode == epphs_pkg::MODE_PS2) begin
				n.pins.dataOut = n.dataLatch;
			end
		end else begin
			unique case (r.st)
			epphs_pkg::XF_IDLE: begin
				n.pins.strobeN = 1'b1;
				if (r.mode == epphs_pkg::MODE_COMPAT_FIFO_PORT) begin
					n.pins.autoFdN =
						!r.lineCtrl[epphs_pkg::LC_AUTOFD];
				end else if (!dirIn) begin
					n.pins.autoFdN = 1'b1;
				end
				if (txMode && !fifoEmpty
					&& (r.mode == epphs_pkg::MODE_COMPAT_FIFO_PORT
					|| pinsIn.paperErrorLine)) begin
					fifoPop = 1'b1;
					n.pins.dataOut = fifoPopData.value;
					if (fwdEcp) begin
						// Low marks a command byte
						n.pins.autoFdN = !fifoPopData.isCmd;
					end
					n.st = epphs_pkg::XF_SETUP;
				end else if (revEcp && !pinsIn.paperErrorLine
					&& !fifoFull && r.repLeft == 8'h00) begin
					n.pins.autoFdN = 1'b0;
					n.st = epphs_pkg::RV_REQ;
				end
			end
			epphs_pkg::XF_SETUP: begin
				// Wait for the peripheral to be ready
				if (!pinsIn.periphBusy) begin
					n.pins.strobeN = 1'b0;
					n.st = epphs_pkg::XF_STROBE;
				end
			end
			epphs_pkg::XF_STROBE: begin
				// Hold strobe until busy confirms the latch
				if (pinsIn.periphBusy) begin
					n.pins.strobeN = 1'b1;
					n.st = epphs_pkg::XF_RELEASE;
				end
			end
			epphs_pkg::XF_RELEASE: begin
				// Busy falling frees the next byte
				if (!pinsIn.periphBusy) begin
					n.st = epphs_pkg::XF_IDLE;
				end
			end
			epphs_pkg::RV_REQ: begin
				// Ack low means the peripheral drives data
				if (!pinsIn.ackN) begin
					n.pins.autoFdN = 1'b1;
					n.st = epphs_pkg::RV_DONE;
					// Busy low tags a command byte
					if (!pinsIn.periphBusy) begin
						if (!pinsIn.dataIn[epphs_pkg::RLE_CMD_BIT])
						begin
							n.rleCnt  = pinsIn.dataIn;
							n.rlePend = 1'b1;
						end else begin
							fifoPush = 1'b1;
							fifoPushData = '{isCmd: 1'b1,
								value: pinsIn.dataIn};
						end
					end else begin
						fifoPush = 1'b1;
						fifoPushData = '{isCmd: 1'b0,
							value: pinsIn.dataIn};
						if (r.rlePend) begin
							// First copy now, the rest below
							n.repByte = pinsIn.dataIn;
							n.repLeft = r.rleCnt;
							n.rlePend = 1'b0;
						end
					end
				end
			end
			epphs_pkg::RV_DONE: begin
				if (pinsIn.ackN) begin
					n.st = epphs_pkg::XF_IDLE;
				end
			end
			default: begin
				n.st = epphs_pkg::XF_IDLE;
			end
			endcase
		end

		// Expand the pending run one byte per cycle
		if (r.repLeft != 8'h00 && revEcp && !fifoFull) begin
			fifoPush = 1'b1;
			fifoPushData = '{isCmd: 1'b0, value: r.repByte};
			n.repLeft = r.repLeft - 8'h01;
		end

		// DMA paces on the FIFO flags
		n.dmaReq = r.dmaReqEn && fifoMode
			&& ((txMode && !fifoFull) || (revEcp && !fifoEmpty));

		// Hardware set wins over a software clear in the same cycle
		if (!r.dmaReqEn && ((txMode && fifoLevel <= epphs_pkg::SVC_LEVEL)
			|| (revEcp && fifoLevel >= epphs_pkg::SVC_LEVEL))) begin
			n.svcFlag = 1'b1;
		end

		// Fault only counts while forward; it never turns the link
		n.irq = (r.errIrqEn && fwdEcp && faultFell)
			|| (r.lineCtrl[epphs_pkg::LC_ACKIE] && ackRose);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			r <= epphs_pkg::PORT_RST;
		end else begin
			r <= n;
		end
	end

endmodule // epphs_port

//--- test/epphs_port_chk.sv
// Concurrent checks on the parallel port pins and register views.
// Assumes binding to epphs_port; dmaAck strobes are FIFO accesses.
`timescale 1ns/1ps
module epphs_port_chk (
	input wire logic                          clk_sys,
	input wire logic                          resetn,
	input wire logic [epphs_pkg::ADDR_W-1:0]  busAddr,
	input wire logic                          busWrStb,
	input wire logic                          busRdStb,
	input wire logic [epphs_pkg::WORD_W-1:0]  busWrData,
	input wire logic [epphs_pkg::WORD_W-1:0]  busRdData,
	input wire logic                          dmaAck,
	input wire logic                          dmaReq,
	input wire logic                          irq,
	input wire epphs_pkg::epphs_pins_in_type  pinsIn,
	input wire epphs_pkg::epphs_pins_out_type pinsOut
);
	logic [2:0] mode_reg;
	logic       errIe_reg;
	logic       ecrWr;
	logic       ecp;
	logic       rev;
	assign ecrWr = busWrStb && !dmaAck && busAddr == epphs_pkg::OFF_EXT_CTRL;
	assign ecp = mode_reg == epphs_pkg::MODE_ECP;
	assign rev = ecp && !pinsIn.paperErrorLine;
	// Shadow of the mode field, so pin checks know the link state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= epphs_pkg::MODE_RST;
			errIe_reg <= 1'h0;
		end else if (ecrWr) begin
			mode_reg <= busWrData[7:5];
			errIe_reg <= busWrData[4];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	strobe_wait_a: assert property ($fell(pinsOut.strobeN) |->
		!$past(pinsIn.periphBusy)) else $error("strobe while busy");
	strobe_hold_a: assert property (!pinsOut.strobeN &&
		!pinsIn.periphBusy |=> !pinsOut.strobeN) else $error("strobe short");
	strobe_end_a: assert property (!pinsOut.strobeN &&
		pinsIn.periphBusy |=> pinsOut.strobeN) else $error("strobe stuck");
	data_steady_a: assert property (!pinsOut.strobeN |=>
		pinsOut.strobeN || $stable(pinsOut.dataOut))
		else $error("data moved under strobe");
	rev_release_a: assert property (rev && !pinsOut.autoFdN &&
		!pinsIn.ackN |-> ##[1:2] pinsOut.autoFdN) else $error("host ack held");
	rev_interlock_a: assert property (rev && pinsOut.autoFdN &&
		!pinsIn.ackN |=> pinsOut.autoFdN) else $error("early byte request");
	data_release_a: assert property (rev |=> !pinsOut.dataOe)
		else $error("data lines driven in reverse");
	select_off_a: assert property (ecp |=> pinsOut.selectInN)
		else $error("select line asserted in ECP");
	dir_pin_a: assert property (busWrStb && !dmaAck &&
		busAddr == epphs_pkg::OFF_LINE_CTRL |-> ##2 pinsOut.reverseReqN ==
		(ecp ? !$past(busWrData[epphs_pkg::LC_DIR], 2)
		: $past(busWrData[epphs_pkg::LC_INIT], 2)))
		else $error("direction pin wrong");
	dma_mode_a: assert property (dmaReq |->
		$past(mode_reg) == epphs_pkg::MODE_COMPAT_FIFO_PORT
		|| $past(mode_reg) == epphs_pkg::MODE_ECP)
		else $error("DMA request outside FIFO modes");
	fault_irq_a: assert property ($fell(pinsIn.faultN) && ecp &&
		errIe_reg && pinsIn.paperErrorLine |-> ##[1:2] irq)
		else $error("fault interrupt missing");
	fault_rev_a: assert property ($fell(pinsIn.faultN) && rev
		|-> ##1 !irq ##1 !irq) else $error("fault interrupt in reverse");
	mode_read_a: assert property (busRdStb && !dmaAck &&
		busAddr == epphs_pkg::OFF_EXT_CTRL |=> busRdData[7:5] == mode_reg)
		else $error("mode readback wrong");
endmodule // epphs_port_chk

//--- test/epphs_periph_model.sv
// Behavioural ECP peripheral facing the port pins.
// Assumes the bench loads reverse bytes and reads the forward log.
`timescale 1ns/1ps
module epphs_periph_model (
	input wire logic                          clk_sys,
	input wire epphs_pkg::epphs_pins_out_type pinsOut,
	output epphs_pkg::epphs_pins_in_type      pinsIn
);
	logic [8:0] fwdLog [0:15];
	logic [8:0] rvMem [0:3];
	int         xfers;
	int         rvN;
	int         rvIdx;
	int         slow;
	logic       faultLow;
	logic       busy;
	logic       ackN;
	logic       drv;
	logic       pErr = 1'h0;
	logic [7:0] rvByte;
	always @(posedge clk_sys) pErr <= pinsOut.reverseReqN;
	assign pinsIn.ackN = ackN;
	assign pinsIn.periphBusy = busy;
	assign pinsIn.paperErrorLine = pErr;
	assign pinsIn.select = 1'h1;
	assign pinsIn.faultN = !faultLow;
	// Released lines show the inverse, so a stale byte cannot pass
	assign pinsIn.dataIn = pinsOut.dataOe ? pinsOut.dataOut :
		drv ? rvByte : ~rvByte;
	initial begin
		{busy, drv, faultLow, rvByte} = '0;
		ackN = 1'h1;
		{xfers, rvN, rvIdx, slow} = '0;
		forever begin
			@(posedge clk_sys);
			if (pErr && !pinsOut.strobeN) begin
				fwdLog[xfers] = {pinsOut.autoFdN, pinsOut.dataOut};
				repeat (slow) @(posedge clk_sys);
				busy <= 1'h1;
				while (!pinsOut.strobeN) @(posedge clk_sys);
				repeat (slow) @(posedge clk_sys);
				busy <= 1'h0;
				xfers++;
			end else if (!pErr && !pinsOut.autoFdN && pinsOut.selectInN &&
					rvIdx < rvN) begin
				rvByte <= rvMem[rvIdx][7:0];
				busy <= rvMem[rvIdx][8];
				drv <= 1'h1;
				repeat (slow + 1) @(posedge clk_sys);
				ackN <= 1'h0;
				while (!pinsOut.autoFdN) @(posedge clk_sys);
				ackN <= 1'h1;
				drv <= 1'h0;
				rvIdx++;
				xfers++;
			end
		end
	end
endmodule // epphs_periph_model

//--- test/epphs_port_bench.sv
// Self-checking bench for the ECP host-side parallel port.
// Assumes the peripheral model and checker files are compiled first.
`timescale 1ns/1ps
module epphs_port_bench;
	logic                          clk_sys;
	logic                          resetn;
	logic [10:0]                   busAddr;
	logic                          busWrStb;
	logic                          busRdStb;
	logic                          dmaAck;
	logic [7:0]                    busWrData;
	logic [7:0]                    busRdData;
	logic [7:0]                    rv;
	logic                          dmaReq;
	logic                          irq;
	epphs_pkg::epphs_pins_in_type  pinsIn;
	epphs_pkg::epphs_pins_out_type pinsOut;
	int                            n_errors;
	int                            checks;
	localparam logic [10:0] ECR = epphs_pkg::OFF_EXT_CTRL;
	localparam logic [10:0] FIFO = epphs_pkg::OFF_FIFO_PORT;
	localparam logic [10:0] LCR = epphs_pkg::OFF_LINE_CTRL;

	epphs_port u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb),
		.busWrData(busWrData), .busRdData(busRdData), .dmaAck(dmaAck),
		.dmaReq(dmaReq), .irq(irq), .pinsIn(pinsIn), .pinsOut(pinsOut));
	epphs_periph_model u_per (.clk_sys(clk_sys), .pinsOut(pinsOut),
		.pinsIn(pinsIn));

	task automatic test_done();
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [8:0] e,
			input logic [8:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		busAddr <= a;
		busWrData <= d;
		busWrStb <= 1'h1;
		@(posedge clk_sys);
		busWrStb <= 1'h0;
	endtask
	task automatic rdc(input string what, input logic [10:0] a,
			input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		busAddr <= a;
		busRdStb <= 1'h1;
		@(posedge clk_sys);
		busRdStb <= 1'h0;
		#1;
		rv = busRdData & m;
		chk(what, {1'h0, e}, {1'h0, rv});
	endtask
	task automatic wait_xf(input int n);
		for (int k = 0; k < 400 && u_per.xfers < n; k++) @(posedge clk_sys);
		chk("transfer count", 9'(n), 9'(u_per.xfers));
		if (n_errors != 0) test_done();
	endtask
	task automatic count_irq(input logic [8:0] e);
		logic [8:0] n;
		n = '0;
		u_per.faultLow <= 1'h1;
		repeat (6) begin
			@(posedge clk_sys);
			#1;
			n = n + irq;
		end
		u_per.faultLow <= 1'h0;
		chk("irq pulses", e, n);
	endtask

	task automatic t_reset();
		rdc("ext ctrl", ECR, 8'hfb, 8'h01);
		rdc("line ctrl", LCR, 8'hff, 8'h00);
		rdc("status", epphs_pkg::OFF_LINE_STATUS, 8'hff, 8'hd8);
		rdc("data latch", epphs_pkg::OFF_PORT_DATA, 8'hff, 8'h00);
		rdc("unmapped", 11'h003, 8'hff, 8'h00);
	endtask
	task automatic t_config();
		wr(ECR, 8'he0);
		rdc("capability a", FIFO, 8'hff, epphs_pkg::CAP_A_VALUE);
		rdc("capability b", epphs_pkg::OFF_CAP_B, 8'hff, 8'h00);
	endtask
	task automatic t_loop();
		wr(ECR, 8'hc0);
		// One write past the depth, which must be dropped
		for (int i = 0; i < 17; i++) wr(FIFO, 8'(8'h30 + i));
		rdc("full flag", ECR, 8'h03, 8'h02);
		for (int i = 0; i < 16; i++) begin
			rdc("loop byte", FIFO, 8'hff, 8'(8'h30 + i));
		end
		rdc("empty flag", ECR, 8'h03, 8'h01);
		rdc("reread", FIFO, 8'hff, 8'h3f);
	endtask
	task automatic t_compat();
		wr(LCR, 8'h04);
		wr(ECR, 8'h00);
		wr(ECR, 8'h40);
		u_per.slow = 2;
		wr(FIFO, 8'ha1);
		wr(FIFO, 8'ha2);
		wait_xf(2);
		chk("compat byte", 9'h1a1, u_per.fwdLog[0]);
		chk("compat byte", 9'h1a2, u_per.fwdLog[1]);
	endtask
	task automatic t_fwd();
		u_per.slow = 0;
		wr(ECR, 8'h60);
		wr(epphs_pkg::OFF_PORT_DATA, 8'h05);
		wr(FIFO, 8'hc3);
		wr(FIFO, 8'h3c);
		wait_xf(5);
		chk("command byte", 9'h005, u_per.fwdLog[2]);
		chk("data byte", 9'h1c3, u_per.fwdLog[3]);
		chk("data byte", 9'h13c, u_per.fwdLog[4]);
		chk("select line", 9'h001, {8'h00, pinsOut.selectInN});
		rdc("status", epphs_pkg::OFF_LINE_STATUS, 8'hff, 8'hf8);
		wr(ECR, 8'h70);
		count_irq(9'h001);
	endtask
	task automatic t_rev();
		wr(LCR, 8'h20);
		u_per.rvMem[0] = 9'h002;
		u_per.rvMem[1] = 9'h15a;
		u_per.rvMem[2] = 9'h133;
		u_per.rvN = 3;
		wait_xf(8);
		chk("reverse pin", 9'h000, {8'h00, pinsOut.reverseReqN});
		chk("data drive", 9'h000, {8'h00, pinsOut.dataOe});
		count_irq(9'h000);
		// First byte leaves by a DMA acknowledge, off the FIFO address
		wr(ECR, 8'h68);
		dmaAck <= 1'h1;
		rdc("dma byte", 11'h000, 8'hff, 8'h5a);
		dmaAck <= 1'h0;
		chk("dma request", 9'h001, {8'h00, dmaReq});
		for (int i = 0; i < 2; i++) begin
			rdc("rle byte", FIFO, 8'hff, 8'h5a);
		end
		rdc("reverse byte", FIFO, 8'hff, 8'h33);
		rdc("empty flag", ECR, 8'h03, 8'h01);
		chk("dma idle", 9'h000, {8'h00, dmaReq});
	endtask

	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		{resetn, busWrStb, busRdStb, dmaAck} = '0;
		busAddr = '0;
		busWrData = '0;
		n_errors = 0;
		checks = 0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'h1;
		t_reset();
		t_config();
		t_loop();
		t_compat();
		t_fwd();
		t_rev();
		test_done();
	end
endmodule // epphs_port_bench

bind epphs_port epphs_port_chk u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb),
	.busWrData(busWrData), .busRdData(busRdData), .dmaAck(dmaAck),
	.dmaReq(dmaReq), .irq(irq), .pinsIn(pinsIn), .pinsOut(pinsOut));
